/* File: ctx_check_pkg.sv */
// Purpose: Shared constants and types for the stage 1 context field check
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Descriptor field positions refer to the 64-bit context descriptor word; config and event positions to 32-bit registers

package ctx_check_pkg;

    // Context descriptor field positions
    localparam int TBI_LOW_BIT  = 38;
    localparam int TBI_HIGH_BIT = 39;
    localparam int PAB_BIT      = 40;
    localparam int FMT_BIT      = 41;

    // Table format encodings
    localparam logic FMT_32 = 1'b0;
    localparam logic FMT_64 = 1'b1;

    // Privilege configuration encodings
    localparam logic [1:0] PRIV_USE_INCOMING = 2'h0;
    localparam logic [1:0] PRIV_FORCE_UNPRIV = 2'h1;
    localparam logic [1:0] PRIV_FORCE_PRIV   = 2'h2;

    // Register offsets
    localparam logic [11:0] OFS_CTX_LO  = 12'h000;
    localparam logic [11:0] OFS_CTX_HI  = 12'h004;
    localparam logic [11:0] OFS_CONFIG  = 12'h008;
    localparam logic [11:0] OFS_STATUS  = 12'h00c;
    localparam logic [11:0] OFS_MASK    = 12'h010;
    localparam logic [11:0] OFS_CHECK   = 12'h014;

    // Config register field positions
    localparam int CFG_WORLD_LSB   = 0;
    localparam int CFG_PRIV_LSB    = 3;
    localparam int CFG_S2_ACT_BIT  = 5;
    localparam int CFG_S2_FMT_BIT  = 6;
    localparam int CFG_HAD_BIT     = 7;
    localparam int CFG_TTF_LSB     = 8;

    // Event bit positions in status and mask
    localparam int EV_CFG_ERR   = 0;
    localparam int EV_TBI_FAULT = 1;
    localparam int EV_PAB_DENY  = 2;
    localparam int EV_WIDTH     = 3;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0300;

    // Stream world encodings
    typedef enum logic [2:0] {
        WORLD_NS_EL1  = 3'h0,
        WORLD_S_EL1   = 3'h1,
        WORLD_EL2     = 3'h2,
        WORLD_EL2_E2H = 3'h3,
        WORLD_EL3     = 3'h4
    } stream_world_t;

    // One transaction to be checked
    typedef struct packed {
        logic [63:0] va;
        logic        high_base;
        logic        data_access;
        logic        instr_fetch;
        logic        client_priv;
        logic [1:0]  page_ap;
        logic        table_ap0_any;
        logic        page_pxn;
    } txn_t;

    // Verdict for one transaction
    typedef struct packed {
        logic ctx_invalid;
        logic tbi_fault;
        logic pab_deny;
        logic pxn_forced;
        logic privileged;
        logic allow;
        logic fmt64;
    } verdict_t;

endpackage

/* File: ctx_field_check.sv */
// Purpose: Decode and check four stage 1 context descriptor fields
// Assumes: Requests are synchronous to pclk; one check per cycle that the request is high
// Notes:   Verdict appears one cycle after the request; APB answers with no wait
//
// Chosen here: the placing of the registers and the APB register port.

`timescale 1ns/10ps
`default_nettype none

module ctx_field_check (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Transaction check
    input  wire logic                      check_req,
    input  wire ctx_check_pkg::txn_t       check_txn,
    output ctx_check_pkg::verdict_t        verdict,
    output logic                           verdict_valid,
    // Features honoured only with the 64-bit format
    output logic                           output_size_enable,
    output logic                           granule_select_enable,
    output logic                           hw_table_update_enable,
    // Interrupt
    output logic                           irq
);
    import ctx_check_pkg::*;

    logic [31:0]         ctx_lo;
    logic [31:0]         ctx_hi;
    logic [31:0]         config_reg;
    logic [EV_WIDTH-1:0] status;
    logic [EV_WIDTH-1:0] mask;
    logic [2:0]          check_count;

    // Worlds in which the high-base top byte ignore and the privileged access block are gated off
    function automatic logic is_high_world(input stream_world_t w);
        return (w == WORLD_EL2) || (w == WORLD_EL2_E2H) || (w == WORLD_EL3);
    endfunction

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Configuration decode
    wire stream_world_t stream_world_a     = stream_world_t'(config_reg[CFG_WORLD_LSB +: 3]);
    wire logic [1:0]    privilege_config   = config_reg[CFG_PRIV_LSB +: 2];
    wire logic          stage2_active      = config_reg[CFG_S2_ACT_BIT];
    wire logic          stage2_table_format = config_reg[CFG_S2_FMT_BIT];
    wire logic          hierarchical_attr_disable = config_reg[CFG_HAD_BIT];
    wire logic [1:0]    supported_table_formats = config_reg[CFG_TTF_LSB +: 2];
    wire logic          high_world         = is_high_world(stream_world_a);

    // Context fields, seen through the world gating
    wire logic top_byte_ignore_low  = ctx_hi[TBI_LOW_BIT-32];
    wire logic top_byte_ignore_high = ctx_hi[TBI_HIGH_BIT-32] & ~high_world;
    wire logic privileged_access_block = ctx_hi[PAB_BIT-32] & ~high_world;
    wire logic table_format_select  = ctx_hi[FMT_BIT-32];
    wire logic fmt64                = (table_format_select == FMT_64);

    // Format legality
    wire logic illegal32 = (table_format_select == FMT_32) &&
                           (!supported_table_formats[0] ||
                            stream_world_a == WORLD_EL2_E2H ||
                            stream_world_a == WORLD_EL3);
    wire logic illegal64 = fmt64 &&
                           (!supported_table_formats[1] ||
                            (stage2_active && stage2_table_format == FMT_32));
    wire logic ctx_invalid = illegal32 | illegal64;

    // Privilege of the transaction
    wire logic privileged = (privilege_config == PRIV_FORCE_PRIV) ||
                            (privilege_config == PRIV_USE_INCOMING &&
                             check_txn.client_priv);

    // Top byte check
    wire logic sel_tbi     = check_txn.high_base ? top_byte_ignore_high : top_byte_ignore_low;
    wire logic top_mismatch = check_txn.va[63:56] != {8{check_txn.va[55]}};
    wire logic tbi_fault   = top_mismatch && !sel_tbi;

    // Privileged access block
    wire logic user_access = check_txn.page_ap[0] &&
                             (hierarchical_attr_disable || !check_txn.table_ap0_any);
    wire logic pab_deny    = privileged_access_block && privileged &&
                             check_txn.data_access && user_access;

    // User-writable page in 64-bit permission form: AP[2:1] == 01
    wire logic user_writable = fmt64 && (check_txn.page_ap == 2'h1);
    wire logic pxn_forced    = check_txn.page_pxn || user_writable;

    wire verdict_t next_verdict = '{
        ctx_invalid: ctx_invalid,
        tbi_fault:   tbi_fault,
        pab_deny:    pab_deny,
        pxn_forced:  pxn_forced,
        privileged:  privileged,
        allow:       !(ctx_invalid || tbi_fault || pab_deny ||
                       (check_txn.instr_fetch && privileged && pxn_forced)),
        fmt64:       fmt64
    };

    // APB decode
    wire logic        apb_access = psel && penable;
    wire logic        apb_write  = apb_access && pwrite;
    wire logic        hit_lo     = paddr == OFS_CTX_LO;
    wire logic        hit_hi     = paddr == OFS_CTX_HI;
    wire logic        hit_cfg    = paddr == OFS_CONFIG;
    wire logic        hit_status = paddr == OFS_STATUS;
    wire logic        hit_mask   = paddr == OFS_MASK;
    wire logic        hit_check  = paddr == OFS_CHECK;
    wire logic        mapped     = hit_lo | hit_hi | hit_cfg | hit_status | hit_mask | hit_check;
    wire logic [31:0] check_word = {25'h0, check_count, 1'b0, verdict.fmt64,
                                    verdict.allow, verdict.ctx_invalid};
    wire logic [31:0] next_prdata =
        hit_lo     ? ctx_lo :
        hit_hi     ? ctx_hi :
        hit_cfg    ? config_reg :
        hit_status ? {29'h0, status} :
        hit_mask   ? {29'h0, mask} :
        hit_check  ? check_word : 32'h0000_0000;

    // Events; a new event wins over a write-one clear in the same cycle
    wire logic [EV_WIDTH-1:0] events = check_req ?
        {pab_deny, tbi_fault, ctx_invalid} : 3'h0;
    wire logic [EV_WIDTH-1:0] clr = (apb_write && hit_status && pstrb[0]) ?
        pwdata[EV_WIDTH-1:0] : 3'h0;
    wire logic [EV_WIDTH-1:0] next_status = (status & ~clr) | events;
    // Interrupt follows the mask being written, so it never lags a mask change
    wire logic [EV_WIDTH-1:0] next_mask = (apb_write && hit_mask && pstrb[0]) ?
        pwdata[EV_WIDTH-1:0] : mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctx_lo     <= RESET_WORD;
            ctx_hi     <= RESET_WORD;
            config_reg <= CFG_RESET;
            mask       <= 3'h0;
        end else if (apb_write) begin
            if (hit_lo) begin
                ctx_lo <= merge(ctx_lo, pwdata, pstrb);
            end
            if (hit_hi) begin
                ctx_hi <= merge(ctx_hi, pwdata, pstrb);
            end
            if (hit_cfg) begin
                config_reg <= merge(config_reg, pwdata, pstrb);
            end
            if (hit_mask && pstrb[0]) begin
                mask <= pwdata[EV_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 3'h0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & next_mask);
        end
    end

    // Verdict and feature enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verdict                <= '0;
            verdict_valid          <= 1'b0;
            check_count            <= 3'h0;
            output_size_enable     <= 1'b0;
            granule_select_enable  <= 1'b0;
            hw_table_update_enable <= 1'b0;
        end else begin
            verdict_valid          <= check_req;
            output_size_enable     <= fmt64 && !ctx_invalid;
            granule_select_enable  <= fmt64 && !ctx_invalid;
            hw_table_update_enable <= fmt64 && !ctx_invalid;
            if (check_req) begin
                verdict     <= next_verdict;
                check_count <= check_count + 3'h1;
            end
        end
    end

    // APB answer: zero wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // Checks
    a_tbi_low_fault: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && !check_txn.high_base && top_mismatch && !ctx_hi[TBI_LOW_BIT-32]
        |=> verdict.tbi_fault) else $error("low base top byte fault missing");
    a_tbi_high_mask: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && check_txn.high_base && top_mismatch && !high_world &&
        ctx_hi[TBI_HIGH_BIT-32] |=> !verdict.tbi_fault)
        else $error("high base top byte ignore not honoured");
    a_tbi_high_res0: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && check_txn.high_base && top_mismatch && high_world
        |=> verdict.tbi_fault) else $error("high base ignore used in high world");
    a_pab_denies_data: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && ctx_hi[PAB_BIT-32] && !high_world && privileged &&
        check_txn.data_access && check_txn.page_ap[0] && !check_txn.table_ap0_any
        |=> verdict.pab_deny && !verdict.allow) else $error("privileged block missed");
    a_pab_table_drop: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && check_txn.table_ap0_any && !hierarchical_attr_disable
        |=> !verdict.pab_deny) else $error("table bits ignored without disable");
    a_priv_forced: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && privilege_config == PRIV_FORCE_UNPRIV
        |=> !verdict.privileged) else $error("unprivileged stream seen privileged");
    a_pab_high_world: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && high_world |=> !verdict.pab_deny)
        else $error("privileged block acted in high world");
    a_fmt32_illegal: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && !table_format_select && !supported_table_formats[0]
        |=> verdict.ctx_invalid ##0 status[EV_CFG_ERR])
        else $error("illegal 32-bit format accepted");
    a_fmt64_illegal: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && table_format_select && stage2_active && !stage2_table_format
        |=> verdict.ctx_invalid && !verdict.allow)
        else $error("64-bit over 32-bit stage 2 accepted");
    a_feature_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !table_format_select |=> !hw_table_update_enable && !output_size_enable)
        else $error("64-bit features on with 32-bit format");
    a_pxn_forced: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && table_format_select && check_txn.page_ap == 2'h1
        |=> verdict.pxn_forced) else $error("user-writable page not execute-never");
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        |(status & mask) |-> irq) else $error("interrupt missing for unmasked event");
    a_tbi_low_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && !check_txn.high_base && top_mismatch && ctx_hi[TBI_LOW_BIT-32]
        |=> !verdict.tbi_fault) else $error("low base top byte ignore not honoured");
    a_tbi_no_mismatch: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && !top_mismatch |=> !verdict.tbi_fault)
        else $error("top byte fault on canonical address");
    a_pab_had_page: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && ctx_hi[PAB_BIT-32] && !high_world && privileged &&
        check_txn.data_access && check_txn.page_ap[0] && hierarchical_attr_disable
        |=> verdict.pab_deny) else $error("page-only block check missed");
    a_pab_off: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && !ctx_hi[PAB_BIT-32] |=> !verdict.pab_deny)
        else $error("privileged block acted while off");
    a_priv_force: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && privilege_config == PRIV_FORCE_PRIV |=> verdict.privileged)
        else $error("forced privileged stream seen unprivileged");
    a_fmt_report: assert property (@(posedge pclk) disable iff (!presetn)
        check_req |=> verdict.fmt64 == $past(ctx_hi[FMT_BIT-32]))
        else $error("reported table format differs from selection");
    a_fmt32_world: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && !table_format_select && stream_world_a == WORLD_EL3
        |=> verdict.ctx_invalid) else $error("32-bit format accepted in monitor world");
    a_pxn_32: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && !table_format_select |=> verdict.pxn_forced == $past(check_txn.page_pxn))
        else $error("32-bit execute-never altered");
    a_invalid_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        check_req && ctx_invalid |=> !verdict.allow)
        else $error("invalid context let access through");
    a_verdict_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        check_req |=> verdict_valid) else $error("verdict strobe missing");

    c_tbi_fault: cover property (@(posedge pclk) disable iff (!presetn)
        verdict_valid && verdict.tbi_fault);
    c_pab_deny: cover property (@(posedge pclk) disable iff (!presetn)
        verdict_valid && verdict.pab_deny);
    c_cfg_error: cover property (@(posedge pclk) disable iff (!presetn)
        verdict_valid && verdict.ctx_invalid ##1 irq);
    c_allow64: cover property (@(posedge pclk) disable iff (!presetn)
        verdict_valid && verdict.allow && verdict.fmt64);

endmodule

`default_nettype wire

/* File: ctx_client_model.sv */
// Purpose: Client bus master that feeds transactions to the field check
// Assumes: One request per call, driven just after a rising pclk edge
// Notes:   Between requests the payload is scrambled, never left stale

`timescale 1ns/10ps
`default_nettype none

module ctx_client_model (
    // Clock
    input  wire logic            pclk,
    // Request to the checker
    output var logic             check_req,
    output ctx_check_pkg::txn_t  check_txn
);
    import ctx_check_pkg::*;

    initial begin
        check_req = 1'b0;
        check_txn = '0;
    end

    // Back to back calls keep the request high
    task automatic issue(input txn_t t);
        @(posedge pclk);
        check_req <= 1'b1;
        check_txn <= t;
    endtask

    // An idle payload must not look like the last one
    task automatic rest();
        @(posedge pclk);
        check_req <= 1'b0;
        check_txn <= ~check_txn;
    endtask
endmodule

`default_nettype wire

/* File: stage1_context_field_check_test.sv */
// Purpose: Self-checking bench for the context field check
// Assumes: Zero-wait APB answer, verdict one cycle after each request
// Notes:   Shadows of the registers drive the verdict and irq expectations of the verdict monitor; verdict_valid follows req_d

`timescale 1ns/10ps
`default_nettype none

module stage1_context_field_check_test;
    import ctx_check_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, req_d;
    logic        check_req, verdict_valid, irq, os_en, gr_en, hw_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ctx_sh, cfg_sh, mask_sh, cf, hi;
    logic [3:0]  pstrb;
    logic [2:0]  st_sh, chk_n;
    logic [95:0] r;
    txn_t        check_txn, t;
    verdict_t    verdict, exp_d, last_exp;
    int          fail_count, tests_run, seed, i, j;

    ctx_field_check DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .check_req(check_req), .check_txn(check_txn),
        .verdict(verdict), .verdict_valid(verdict_valid), .output_size_enable(os_en),
        .granule_select_enable(gr_en), .hw_table_update_enable(hw_en), .irq(irq));

    ctx_client_model client (.pclk(pclk), .check_req(check_req), .check_txn(check_txn));

    function automatic verdict_t expect_of(txn_t x, logic [31:0] h, logic [31:0] c);
        verdict_t v;
        logic     high, priv;
        high = (c[2:0] >= 3'h2);
        priv = (c[4:3] == PRIV_FORCE_PRIV) || (c[4:3] == PRIV_USE_INCOMING && x.client_priv);
        v.fmt64 = h[9];
        v.ctx_invalid = h[9] ? (!c[9] || (c[5] && !c[6]))
                             : (!c[8] || c[2:0] == 3'h3 || c[2:0] == 3'h4);
        v.tbi_fault = (x.va[63:56] != {8{x.va[55]}})
                      && !(x.high_base ? (h[7] && !high) : h[6]);
        v.pab_deny = h[8] && !high && priv && x.data_access && x.page_ap[0]
                     && (c[7] || !x.table_ap0_any);
        v.pxn_forced = x.page_pxn || (h[9] && x.page_ap == 2'b01);
        v.privileged = priv;
        v.allow = !v.ctx_invalid && !v.tbi_fault && !v.pab_deny
                  && !(priv && x.instr_fetch && v.pxn_forced);
        return v;
    endfunction

    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One APB transfer; shadows follow only after the access edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) fail_count++;
        if (wr && a == OFS_CTX_HI) ctx_sh = d;
        if (wr && a == OFS_CONFIG) cfg_sh = d;
        if (wr && a == OFS_MASK) mask_sh = d;
        if (wr && a == OFS_STATUS) st_sh = st_sh & ~d[2:0];
    endtask

    task automatic setup(input logic [31:0] h, input logic [31:0] c);
        verdict_t v;
        apb(1'b1, OFS_CTX_HI, h);
        apb(1'b1, OFS_CONFIG, c);
        repeat (2) @(posedge pclk);
        v = expect_of('0, h, c);
        check("fmt64_features", {os_en, gr_en, hw_en}, {3{v.fmt64 && !v.ctx_invalid}});
    endtask

    // Verdict monitor: request seen at one edge, answer checked at the falling edge after it
    always @(posedge pclk) begin
        req_d <= (check_req === 1'b1);
        if (check_req === 1'b1) exp_d <= expect_of(check_txn, ctx_sh, cfg_sh);
    end

    always @(negedge pclk) begin
        if (presetn === 1'b1) begin
            check("verdict_valid", verdict_valid, req_d);
            if (req_d) begin
                check("verdict", verdict, exp_d);
                st_sh = st_sh | {exp_d.pab_deny, exp_d.tbi_fault, exp_d.ctx_invalid};
                check("irq", irq, |(st_sh & mask_sh[2:0]));
                last_exp = exp_d;
                chk_n = chk_n + 3'h1;
            end
        end
    end

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Run is some 4150 cycles; over fourteen times that is a hang
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, req_d, st_sh, chk_n} = '0;
        {ctx_sh, mask_sh, fail_count, tests_run} = '0;
        cfg_sh = CFG_RESET;
        seed = 32'h0653;
        repeat (20) @(posedge pclk);
        check("outputs_in_reset", {irq, pready, verdict_valid}, 3'h0);
        presetn <= 1'b1;
        // Reset values, then one unmapped word
        for (i = 0; i < 7; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            check("reg_reset", {err, rd}, {1'(i == 6), (i == 2) ? CFG_RESET : RESET_WORD});
        end
        apb(1'b1, OFS_MASK, 32'h7);
        for (i = 0; i < 240; i++) begin
            cf = $random(seed);
            cf[2:0] = 3'(i % 5);
            cf[4:3] = 2'((i / 5) % 3);
            hi = $random(seed);
            setup(hi, cf);
            for (j = 0; j < 4; j++) begin
                r = {$random(seed), $random(seed), $random(seed)};
                t = r[71:0];
                if (r[80]) t.va[63:56] = {8{t.va[55]}};
                client.issue(t);
            end
            client.rest();
            @(posedge pclk);
            apb(1'b0, OFS_CHECK, 32'h0);
            check("check_reg", rd[6:0], {chk_n, 1'b0, last_exp.fmt64, last_exp.allow,
                  last_exp.ctx_invalid});
        end
        // Masked event, then raise and clear the interrupt
        apb(1'b1, OFS_STATUS, 32'h7);
        apb(1'b1, OFS_MASK, 32'h0);
        setup(32'h0000_0200, CFG_RESET);
        t = '0;
        t.va = 64'hff00_0000_0000_0000;
        client.issue(t);
        client.rest();
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status_tbi", rd[2:0], 3'h2);
        apb(1'b1, OFS_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        check("irq_unmasked", irq, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h2);
        repeat (2) @(posedge pclk);
        check("irq_cleared", irq, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
